// ==== core/hiss_top.sv ====
// hot-insert switch sequencer: power-on reset, qualification, turn-on/off, faults, apb
//
// Operation
// - supply rise starts reset pulse clearing faults
// - inputs in range, card present for 100ms
// - after qualification, on-control or command turns on
// - feedback above threshold releases power-good pin
// - on-control fall or command turns off
// - overvoltage, undervoltage, breaker, removal turn off
// - writing fault one with retry off forces off
// - feedback below threshold pulls power-good low
// - supply low beyond filter time forces shutdown
// - breaker timer trip sets overcurrent bits, off
// - timer cooled clears present; relatch needs cleared
// - overcurrent retry restarts, fault bit kept
// - high-current trip forces immediate off
// - overvoltage turns off, sets present and fault
// - overvoltage retry after 100ms below threshold
// - undervoltage off, bits, retry after 100ms
// - zero write clears unless present; off clears
// - card present 100ms captures on-control level
`timescale 1ns/1ps
`include "hiss_cfg.svh"
module hiss_top
    import hiss_pkg::*;
#(
    parameter logic [`HISS_QCNT_W-1:0] QUAL_CYC = `HISS_QCNT_W'(`HISS_QUAL_CYC)  // 100 ms
) (
    input  wire logic        pclk,             // 10 MHz clock
    input  wire logic        presetn,          // async reset, active low
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb enable
    input  wire logic        pwrite,           // apb direction
    input  wire logic [7:0]  paddr,            // apb byte address
    input  wire logic [31:0] pwdata,           // apb write data
    output logic [31:0]      prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr,          // apb error
    input  wire logic        supply_ok,        // internal supply above 4.5V lockout
    input  wire logic        main_low,         // main supply below 7.5V
    input  wire logic        internal_low,     // internal supply below 3.8V
    input  wire logic        input_low_compare,  // uv input above threshold (in range)
    input  wire logic        input_high_compare, // ov input above threshold
    input  wire logic        card_present_n,   // board present, active low
    input  wire logic        on_ctrl,          // on-control pin
    input  wire logic        output_feedback,  // feedback above power-good threshold
    input  wire logic        timer_trip,       // breaker timer above 1.2V
    input  wire logic        timer_cool,       // breaker timer below 0.2V
    input  wire logic        high_current,     // sense voltage above 150mV
    output logic             gate_on,          // gate drive request
    output logic             fast_off,         // fast shutdown request
    output logic             gpio_oe           // power-good pin pulls low when high
);
    // ************************************************************
    // synchronisers
    // ************************************************************
    logic s_sok, s_mlow, s_ilow, s_uvok, s_ov, s_card_n, s_on, s_fb, s_trip, s_cool, s_hc;
    logic [10:0] raw_in;    // all asynchronous comparator inputs
    logic [10:0] sync_in;   // after two flops
    assign raw_in = {supply_ok, main_low, internal_low, input_low_compare, input_high_compare,
                     card_present_n, on_ctrl, output_feedback, timer_trip, timer_cool,
                     high_current};
    // each comparator passes through its own two-flop chain
    for (genvar g = 0; g < 11; g++) begin : g_sync
        hiss_sync u_sync (
            .pclk    (pclk),
            .presetn (presetn),
            .din     (raw_in[g]),
            .dout    (sync_in[g])
        );
    end
    assign {s_sok, s_mlow, s_ilow, s_uvok, s_ov, s_card_n, s_on, s_fb, s_trip, s_cool,
            s_hc} = sync_in;

    // ************************************************************
    // qualification and supply filters
    // ************************************************************
    logic qual_ok;          // uv, ov, card all good for 100 ms
    logic card_ok;          // card present for 100 ms
    logic ov_clear_ok;      // ov below threshold for 100 ms
    logic uv_clear_ok;      // uv in range for 100 ms
    logic mlow_f, ilow_f;   // supply lows past their filter times
    logic in_por;           // power-on pulse running; qualification restarts after it

    // one restartable counter per condition
    // qualification and card capture only count once the power-on pulse is over,
    // otherwise the capture edge would fall inside the pulse and be lost
    hiss_filter #(.W(`HISS_QCNT_W), .CYC(QUAL_CYC)) u_qual (
        .pclk(pclk), .presetn(presetn),
        .din(s_uvok & ~s_ov & ~s_card_n & ~in_por), .dout(qual_ok));
    hiss_filter #(.W(`HISS_QCNT_W), .CYC(QUAL_CYC)) u_card (
        .pclk(pclk), .presetn(presetn), .din(~s_card_n & ~in_por), .dout(card_ok));
    hiss_filter #(.W(`HISS_QCNT_W), .CYC(QUAL_CYC)) u_ovq (
        .pclk(pclk), .presetn(presetn), .din(~s_ov), .dout(ov_clear_ok));
    hiss_filter #(.W(`HISS_QCNT_W), .CYC(QUAL_CYC)) u_uvq (
        .pclk(pclk), .presetn(presetn), .din(s_uvok), .dout(uv_clear_ok));
    hiss_filter #(.W(`HISS_FCNT_W), .CYC(`HISS_FCNT_W'(`HISS_VDD_LOW_CYC))) u_mlow (
        .pclk(pclk), .presetn(presetn), .din(s_mlow), .dout(mlow_f));
    hiss_filter #(.W(`HISS_FCNT_W), .CYC(`HISS_FCNT_W'(`HISS_INT_LOW_CYC))) u_ilow (
        .pclk(pclk), .presetn(presetn), .din(s_ilow), .dout(ilow_f));

    // ************************************************************
    // state, control and fault registers
    // ************************************************************
    hiss_state_t state;          // sequencer state
    hiss_state_t next_state;     // combinational next state
    logic [`HISS_FCNT_W-1:0] por_cnt;  // power-on reset pulse length
    logic sok_q;                 // previous supply_ok for rising edge
    logic on_q;                  // previous on-control level
    logic card_q;                // previous card_present_n
    logic card_ok_q;             // previous card_ok
    logic sw_on;                 // switch-on control bit
    logic retry_ov, retry_uv, retry_oc;  // autoretry enables
    logic ov_p, uv_p, oc_p;      // present bits
    logic [5:0] fault;           // fault bits
    logic wr_acc, rd_acc;        // apb access cycles
    logic ctrl_wr, fault_wr;     // register writes
    logic trip;                  // any immediate turn-off cause
    logic hold_off;              // retry gating keeps switch off
    logic sw_fall;               // switch-on bit cleared by pin or write
    logic supply_rise;           // internal supply crossed its lockout

    assign wr_acc   = psel & penable & pwrite;
    assign rd_acc   = psel & penable & ~pwrite;
    assign ctrl_wr  = wr_acc & (paddr == `HISS_A_CTRL);
    assign fault_wr = wr_acc & (paddr == `HISS_A_FAULT);
    assign supply_rise = s_sok & ~sok_q;
    assign in_por      = (state == HISS_ST_POR);

    // edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sok_q     <= 1'b0;
            on_q      <= 1'b0;
            card_q    <= 1'b0;  // matches the synchroniser reset, no false edge
            card_ok_q <= 1'b0;
        end else begin
            sok_q     <= s_sok;
            on_q      <= s_on;
            card_q    <= s_card_n;
            card_ok_q <= card_ok;
        end
    end

    // switch-on bit: pin edges, capture after card settles, commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_on <= 1'b0;
        end else if (state == HISS_ST_POR) begin
            sw_on <= 1'b0;
        end else if (card_ok & ~card_ok_q) begin
            sw_on <= s_on;
        end else if (s_on & ~on_q) begin
            sw_on <= 1'b1;
        end else if (~s_on & on_q) begin
            sw_on <= 1'b0;
        end else if (ctrl_wr) begin
            sw_on <= pwdata[`HISS_C_SW_ON];
        end
    end
    assign sw_fall = (~s_on & on_q) | (ctrl_wr & sw_on & ~pwdata[`HISS_C_SW_ON]);

    // autoretry enables, defaults restored by power-on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retry_ov <= `HISS_RETRY_OV_RST;
            retry_uv <= `HISS_RETRY_UV_RST;
            retry_oc <= `HISS_RETRY_OC_RST;
        end else if (state == HISS_ST_POR) begin
            retry_ov <= `HISS_RETRY_OV_RST;
            retry_uv <= `HISS_RETRY_UV_RST;
            retry_oc <= `HISS_RETRY_OC_RST;
        end else if (ctrl_wr) begin
            retry_ov <= pwdata[`HISS_C_RETRY_OV];
            retry_uv <= pwdata[`HISS_C_RETRY_UV];
            retry_oc <= pwdata[`HISS_C_RETRY_OC];
        end
    end

    // ov_p and uv_p track the live conditions; oc_p sets on a trip while on and clears when cooled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ov_p <= 1'b0;
            uv_p <= 1'b0;
            oc_p <= 1'b0;
        end else begin
            ov_p <= s_ov;
            uv_p <= ~s_uvok;
            if (state == HISS_ST_ON && s_trip) begin
                oc_p <= 1'b1;
            end else if (s_cool) begin
                oc_p <= 1'b0;
            end
        end
    end

    // fault bits: hardware set wins over software clear; present faults stick through fault writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault <= '0;
        end else if (state == HISS_ST_POR) begin
            fault <= '0;
        end else begin
            // clears come first so that the sets below override them
            if (sw_fall) begin
                fault <= '0;
            end else if (~s_card_n & card_q) begin
                fault[`HISS_B_OV] <= 1'b0;
                fault[`HISS_B_UV] <= 1'b0;
                fault[`HISS_B_OC] <= 1'b0;
            end else if (fault_wr) begin
                fault[`HISS_B_OV] <= pwdata[`HISS_B_OV] | ov_p;
                fault[`HISS_B_UV] <= pwdata[`HISS_B_UV] | uv_p;
                fault[`HISS_B_OC] <= pwdata[`HISS_B_OC] | oc_p;
                fault[`HISS_B_BP] <= pwdata[`HISS_B_BP];
            end
            if (s_card_n != card_q) begin
                fault[`HISS_B_BP] <= 1'b1;
            end
            if (s_ov) begin
                fault[`HISS_B_OV] <= 1'b1;
            end
            if (!s_uvok) begin
                fault[`HISS_B_UV] <= 1'b1;
            end
            if (state == HISS_ST_ON && s_trip) begin
                fault[`HISS_B_OC] <= 1'b1;
            end
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    assign trip = s_ov | ~s_uvok | s_card_n | s_trip | s_hc | mlow_f | ilow_f;
    // latched-off faults block turn-on; with retry on only present bits and 100 ms
    assign hold_off =
        (retry_ov ? (ov_p | ~ov_clear_ok) : fault[`HISS_B_OV]) |
        (retry_uv ? (uv_p | ~uv_clear_ok) : fault[`HISS_B_UV]) |
        (retry_oc ? oc_p : (oc_p | fault[`HISS_B_OC]));

    // next-state decision
    always_comb begin
        next_state = state;
        case (state)
            HISS_ST_POR: begin
                if (por_cnt >= `HISS_FCNT_W'(`HISS_POR_CYC) - 1'b1) begin
                    next_state = HISS_ST_QUAL;
                end
            end
            HISS_ST_QUAL: begin
                if (qual_ok) begin
                    next_state = HISS_ST_OFF;
                end
            end
            HISS_ST_OFF: begin
                if (!qual_ok && s_card_n) begin
                    next_state = HISS_ST_QUAL;
                end else if (sw_on && !trip && !hold_off) begin
                    next_state = HISS_ST_ON;
                end
            end
            HISS_ST_ON: begin
                if (trip || !sw_on || hold_off) begin
                    next_state = HISS_ST_OFF;
                end
            end
            default: next_state = HISS_ST_POR;
        endcase
    end

    // state register; supply rising edge restarts the power-on pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= HISS_ST_POR;
            por_cnt <= '0;
        end else if (supply_rise) begin
            state   <= HISS_ST_POR;
            por_cnt <= '0;
        end else begin
            state   <= next_state;
            por_cnt <= (state == HISS_ST_POR) ? por_cnt + 1'b1 : '0;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // gate and power-good drive from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_on  <= 1'b0;
            fast_off <= 1'b0;
            gpio_oe  <= 1'b1;
        end else begin
            gate_on  <= (next_state == HISS_ST_ON) && !supply_rise;
            fast_off <= mlow_f | ilow_f | s_hc;
            gpio_oe  <= ~s_fb;
        end
    end

    // ************************************************************
    // apb slave, zero wait states
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr != `HISS_A_CTRL) &
                       (paddr != `HISS_A_FAULT) & (paddr != `HISS_A_STATUS);
            prdata  <= '0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `HISS_A_CTRL:   prdata <= {28'h0, sw_on, retry_oc, retry_uv, retry_ov};
                    `HISS_A_FAULT:  prdata <= {26'h0, fault};
                    `HISS_A_STATUS: prdata <= {22'h0, gate_on, state, ~s_card_n, ~s_fb,
                                               oc_p, uv_p, ov_p};
                    default:        prdata <= '0;
                endcase
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_ov_trip_off: assert property (@(posedge pclk) disable iff (!presetn)
        (state == HISS_ST_ON && s_ov) |=> (state == HISS_ST_OFF && fault[`HISS_B_OV]))
        else $error("overvoltage did not turn switch off");
    a_breaker_off: assert property (@(posedge pclk) disable iff (!presetn)
        (state == HISS_ST_ON && s_trip) |=> (oc_p && fault[`HISS_B_OC] && !gate_on))
        else $error("breaker trip did not set bits");
    a_hc_off: assert property (@(posedge pclk) disable iff (!presetn)
        s_hc |=> (!gate_on && fast_off))
        else $error("high current did not force off");
    a_pgood_pin: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_fb) |=> !gpio_oe)
        else $error("power good not released");
    a_pbad_pin: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(s_fb) |=> gpio_oe)
        else $error("power bad not signalled");
    a_card_off: assert property (@(posedge pclk) disable iff (!presetn)
        (state == HISS_ST_ON && s_card_n) |=> state == HISS_ST_OFF)
        else $error("card removal did not turn off");
    a_on_fall_off: assert property (@(posedge pclk) disable iff (!presetn)
        (state == HISS_ST_ON && on_q && !s_on) |=> ##1 !gate_on)
        else $error("on-control fall did not turn off");
    a_cool_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (s_cool && !(state == HISS_ST_ON && s_trip)) |=> !oc_p)
        else $error("cooled timer left present bit");
    a_por_clear: assert property (@(posedge pclk) disable iff (!presetn)
        supply_rise |=> ##1 (fault == '0 && !sw_on))
        else $error("power-on reset did not clear");
endmodule

// ==== core/hiss_cfg.svh ====
// timing constants, bit positions and reset values for the hot-insert switch sequencer
`ifndef HISS_CFG_SVH
`define HISS_CFG_SVH

// clock rate in kHz (10 MHz)
`define HISS_CLK_KHZ          10000
// qualification time in ms and its cycle count
`define HISS_QUAL_MS          100
`define HISS_QUAL_CYC         (`HISS_QUAL_MS * `HISS_CLK_KHZ)
// main supply low filter in us (least time, rounds up)
`define HISS_VDD_LOW_US       5
`define HISS_VDD_LOW_CYC      ((`HISS_VDD_LOW_US * `HISS_CLK_KHZ + 999) / 1000)
// internal supply low filter in us
`define HISS_INT_LOW_US       1
`define HISS_INT_LOW_CYC      ((`HISS_INT_LOW_US * `HISS_CLK_KHZ + 999) / 1000)
// power-on reset pulse, least 60 us
`define HISS_POR_US           60
`define HISS_POR_CYC          ((`HISS_POR_US * `HISS_CLK_KHZ + 999) / 1000)
// counter widths
`define HISS_QCNT_W           20
`define HISS_FCNT_W           10

// fault and status bit positions
`define HISS_B_OV             0
`define HISS_B_UV             1
`define HISS_B_OC             2
`define HISS_B_BP             4

// control defaults after power-on reset
`define HISS_RETRY_OV_RST     1'b1
`define HISS_RETRY_UV_RST     1'b1
`define HISS_RETRY_OC_RST     1'b0

// register map (byte offsets)
`define HISS_A_CTRL           8'h00
`define HISS_A_FAULT          8'h04
`define HISS_A_STATUS         8'h08
// control register bit positions
`define HISS_C_RETRY_OV       0
`define HISS_C_RETRY_UV       1
`define HISS_C_RETRY_OC       2
`define HISS_C_SW_ON          3

`endif

// ==== core/hiss_pkg.sv ====
// types shared by the hot-insert switch sequencer files
package hiss_pkg;
    // switch sequencer states, one-hot
    typedef enum logic [3:0] {
        HISS_ST_POR  = 4'b0001,  // power-on reset pulse
        HISS_ST_QUAL = 4'b0010,  // waiting for qualified inputs
        HISS_ST_OFF  = 4'b0100,  // qualified, switch off
        HISS_ST_ON   = 4'b1000   // switch on
    } hiss_state_t;
endpackage

// ==== core/hiss_sync.sv ====
// two-flop synchroniser for one comparator level
`timescale 1ns/1ps
module hiss_sync (
    input  wire logic pclk,      // system clock
    input  wire logic presetn,   // async reset, active low
    input  wire logic din,       // asynchronous level
    output logic      dout       // synchronised level
);
    logic meta;                  // first stage, read only by dout

    // the first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ==== core/hiss_filter.sv ====
// holds a level high only after its input stays high for a set count
`timescale 1ns/1ps
module hiss_filter #(
    parameter int                W   = 10,  // counter width
    parameter logic [W-1:0]      CYC = '1   // cycles the input must stay high
) (
    input  wire logic pclk,      // system clock
    input  wire logic presetn,   // async reset, active low
    input  wire logic din,       // condition to qualify
    output logic      dout       // high once condition held for CYC cycles
);
    logic [W-1:0] cnt;           // cycles seen so far

    // count while high, restart on any drop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= '0;
            dout <= 1'b0;
        end else if (!din) begin
            cnt  <= '0;
            dout <= 1'b0;
        end else if (cnt >= CYC - 1'b1) begin
            dout <= 1'b1;
        end else begin
            cnt  <= cnt + 1'b1;
        end
    end
endmodule

// ==== tb/hiss_power_model.sv ====
// power path model: output feedback follows the gate request after a ramp
`timescale 1ns/1ps
module hiss_power_model (
    input  wire logic pclk,            // system clock
    input  wire logic presetn,         // async reset, active low
    input  wire logic slow,            // high for a slow output ramp
    input  wire logic gate_on,         // gate drive request from the block
    output logic      output_feedback  // output above the power-good level
);
    logic [5:0] ramp;  // cycles since gate and feedback disagreed

    // feedback lags the gate so that power-good never moves with the gate edge itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp <= 6'h00;
            output_feedback <= 1'b0;
        end else if (gate_on == output_feedback) begin
            ramp <= 6'h00;  // settled, nothing to ramp
        end else if (ramp >= (slow ? 6'h1E : 6'h03)) begin
            output_feedback <= gate_on;
        end else begin
            ramp <= ramp + 6'h01;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the hot-insert switch sequencer
`timescale 1ns/1ps
`include "hiss_cfg.svh"
module testbench;
    // ************
    // signals
    // ************
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        slow = 1'b0, supply_ok = 1'b0, main_low = 1'b0, input_high_compare = 1'b0;
    logic        input_low_compare = 1'b1, card_present_n = 1'b0, on_ctrl = 1'b1;
    logic        timer_trip = 1'b0, timer_cool = 1'b1, high_current = 1'b0, internal_low = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, output_feedback, gate_on, fast_off, gpio_oe;
    logic [64:0] exp_q[$];  // read notes: {error, mask, data}
    logic [64:0] note;      // oldest note being compared
    int          err_count = 0, checks = 0;

    always #50 pclk = ~pclk;  // 10 MHz

    hiss_top #(.QUAL_CYC(20'd50)) i_hiss_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok), .main_low(main_low),
        .internal_low(internal_low), .input_low_compare(input_low_compare),
        .input_high_compare(input_high_compare), .card_present_n(card_present_n),
        .on_ctrl(on_ctrl), .output_feedback(output_feedback), .timer_trip(timer_trip),
        .timer_cool(timer_cool), .high_current(high_current), .gate_on(gate_on),
        .fast_off(fast_off), .gpio_oe(gpio_oe));
    hiss_power_model i_hiss_power_model (.pclk(pclk), .presetn(presetn), .slow(slow),
        .gate_on(gate_on), .output_feedback(output_feedback));

    // ************
    // tasks
    // ************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer; waits for pready with no assumed latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);  // idle cycle keeps two transfers from colliding in one step
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic er);
        exp_q.push_back({er, m, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic st(input logic [31:0] e);  // status: gate, card, power bad, present bits
        rd(`HISS_A_STATUS, e, 32'h21F, 1'b0);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // monitor: each completed read takes the oldest note off the queue
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            note = exp_q.pop_front();
            check(prdata & note[63:32], note[31:0]);
            check({31'h0, pslverr}, {31'h0, note[64]});
        end
    end

    // watchdog: the run needs about 2100 cycles
    initial begin
        idle(20000);
        err_count++;
        finish_test();
    end

    initial begin
        void'($urandom(65));
        idle(10);
        presetn <= 1'b1;
        supply_ok <= 1'b1;
        idle(1);
        rd(`HISS_A_CTRL, 32'h3, 32'hF, 1'b0);
        rd(`HISS_A_FAULT, 32'h0, 32'h7, 1'b0);
        idle(800 + $urandom_range(0, 7));
        rd(`HISS_A_CTRL, 32'hB, 32'hF, 1'b0);
        st(32'h210);
        done("power_up");
        input_high_compare <= 1'b1;
        idle(10);
        st(32'h019);
        rd(`HISS_A_FAULT, 32'h1, 32'h7, 1'b0);
        input_high_compare <= 1'b0;
        idle(100);
        st(32'h210);
        rd(`HISS_A_FAULT, 32'h1, 32'h7, 1'b0);
        apb(1'b1, `HISS_A_FAULT, 32'h0);
        rd(`HISS_A_FAULT, 32'h0, 32'h7, 1'b0);
        apb(1'b1, `HISS_A_CTRL, 32'hA);
        apb(1'b1, `HISS_A_FAULT, 32'h1);
        idle(10);
        st(32'h018);
        apb(1'b1, `HISS_A_CTRL, 32'hB);
        idle(100);
        st(32'h210);
        apb(1'b1, `HISS_A_FAULT, 32'h0);
        done("overvoltage");
        slow <= 1'b1;
        input_low_compare <= 1'b0;
        idle(40);  // the slow ramp needs about 35 cycles before power-bad shows
        st(32'h01A);
        rd(`HISS_A_FAULT, 32'h2, 32'h7, 1'b0);
        input_low_compare <= 1'b1;
        idle(100);
        st(32'h210);
        apb(1'b1, `HISS_A_FAULT, 32'h0);
        slow <= 1'b0;
        done("undervoltage");
        for (int r = 0; r < 2; r++) begin
            timer_cool <= 1'b0;
            timer_trip <= 1'b1;
            idle(10);
            timer_trip <= 1'b0;
            st(32'h01C);
            rd(`HISS_A_FAULT, 32'h4, 32'h7, 1'b0);
            timer_cool <= 1'b1;
            idle(100);
            st(r ? 32'h210 : 32'h018);
            apb(1'b1, `HISS_A_FAULT, 32'h0);
            idle(100);
            st(32'h210);
            apb(1'b1, `HISS_A_CTRL, 32'hF);
        end
        done("overcurrent");
        high_current <= 1'b1;
        idle(6);
        high_current <= 1'b0;
        check({31'h0, gate_on}, 32'h0);
        on_ctrl <= 1'b0;
        idle(10);
        st(32'h018);
        rd(`HISS_A_FAULT, 32'h0, 32'h7, 1'b0);
        apb(1'b1, `HISS_A_CTRL, 32'hF);
        idle(100);
        st(32'h210);
        on_ctrl <= 1'b1;
        done("on_off");
        card_present_n <= 1'b1;
        idle(50);
        st(32'h008);
        check({31'h0, gpio_oe}, 32'h1);
        card_present_n <= 1'b0;
        idle(120);
        st(32'h210);
        check({31'h0, gpio_oe}, 32'h0);
        done("card");
        main_low <= 1'b1;
        idle(20);
        check({31'h0, fast_off}, 32'h0);
        idle(60);
        check({31'h0, fast_off}, 32'h1);
        main_low <= 1'b0;
        internal_low <= 1'b1;
        idle(8);
        check({31'h0, fast_off}, 32'h0);
        idle(12);
        check({31'h0, fast_off}, 32'h1);
        internal_low <= 1'b0;
        apb(1'b1, 8'h10, $urandom);
        rd(8'h0C, 32'h0, 32'hFFFFFFFF, 1'b1);
        done("fast_off_unmapped");
        finish_test();
    end
endmodule
